// ===== tb/rws_partner.sv
// wait-state counter and address decode beside the block
// assumes the cycle-done line level is fed back as done_n
`timescale 1ns/1ps
`default_nettype none
module rws_partner (
  input  wire logic                    core_clk,
  input  wire logic                    reset_out,
  input  wire logic                    done_n,
  input  wire rws_pkg::rws_status_t    status_in,
  input  wire logic [1:0]              waits,
  input  wire logic                    sys_bus,
  output wire rws_pkg::rws_ready_sel_t ready_sel
);
  logic [3:0] cnt_q;
  // counts clocks, two per added wait state
  always_ff @(posedge core_clk) begin
    if (reset_out || !done_n || &status_in) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // tap decoded from the clocked count, so sync ready never moves near the edge
  wire tap_n = ({1'h0, waits, 1'h0} + 4'h2) > cnt_q;
  assign ready_sel = {tap_n, sys_bus, !sys_bus};
endmodule : rws_partner
`default_nettype wire

// ===== tb/rws_top_assertions.sv
// checker for cycle-done, reset and peripheral clock behaviour
// assumes it is bound to every rws_top instance
`timescale 1ns/1ps
`default_nettype none
module rws_top_assertions #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic                    core_clk,
  input wire logic                    rst_b,
  input wire rws_pkg::rws_status_t    status_in,
  input wire rws_pkg::rws_ready_sel_t ready_sel,
  input wire logic                    async_ready_in_n,
  input wire logic                    reset_request_n,
  input wire logic                    ready_out,
  input wire logic                    ready_oe_n,
  input wire logic                    reset_out,
  input wire logic                    periph_clk
);
  wire sync_ok = !ready_sel.sync_ready_enable_n &&
                 !ready_sel.sync_ready_in_n;
  wire async_off = ready_sel.async_ready_enable_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    $past(&status_in) && !(&status_in) && !reset_out;
  endsequence
  sequence s_float2;
    ready_oe_n ##1 ready_oe_n;
  endsequence
  a_data_low: assert property (ready_out == 1'h0)
    else $error("cycle-done data not low");
  a_reset_done: assert property (
    reset_out && $past(reset_out) |-> !ready_oe_n)
    else $error("cycle-done not held low in reset");
  a_pclk_reset: assert property (
    reset_out && $past(reset_out) |-> !periph_clk)
    else $error("peripheral clock runs in reset");
  a_reset_set: assert property (
    $fell(reset_request_n) |-> ##3 reset_out)
    else $error("reset output late on request");
  a_reset_clr: assert property (
    $rose(reset_request_n) |-> ##3 !reset_out)
    else $error("reset output late on release");
  a_start_float: assert property (s_start |=> s_float2)
    else $error("cycle-done not floated at start");
  a_sync_done: assert property (
    s_start ##2 (sync_ok && async_off) |=> !ready_oe_n)
    else $error("sync ready did not end cycle");
  a_wait_ins: assert property (
    s_start ##2 (!sync_ok && async_off) |=> s_float2)
    else $error("wait state missing");
  a_async_done: assert property (
    s_start ##1 (!async_off && !$past(async_ready_in_n, 2) &&
    !$past(async_ready_in_n)) |-> ##2 !ready_oe_n)
    else $error("async ready did not end cycle");
endmodule : rws_top_assertions
bind rws_top rws_top_assertions #(.SYNC_STAGES(SYNC_STAGES)) u_chk (
  .core_clk, .rst_b, .status_in, .ready_sel, .async_ready_in_n,
  .reset_request_n, .ready_out, .ready_oe_n, .reset_out, .periph_clk);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the ready, reset and peripheral clock block
// assumes a pull-up on the cycle-done line
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                    core_clk = 1'h0;
  logic                    rst_b = 1'h0;
  logic                    reset_request_n = 1'h0;
  logic                    async_ready_in_n = 1'h1;
  logic                    sys_bus = 1'h0;
  logic [1:0]              waits = 2'h0;
  rws_pkg::rws_status_t    status_in = 2'h3;
  rws_pkg::rws_ready_sel_t ready_sel;
  logic                    ready_out, ready_oe_n, reset_out, periph_clk;
  int                      err_total = 0;
  int                      comparisons = 0;
  wire done_n = ready_oe_n ? 1'h1 : ready_out;
  always #10 core_clk = ~core_clk;
  rws_top u_dut (.core_clk, .rst_b, .status_in, .ready_sel,
    .async_ready_in_n, .reset_request_n, .ready_out, .ready_oe_n,
    .reset_out, .periph_clk);
  rws_partner u_far (.core_clk, .reset_out, .done_n, .status_in, .waits,
    .sys_bus, .ready_sel);
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic req(input logic lvl);
    int n;
    n = 0;
    reset_request_n = !lvl;
    do begin
      @(negedge core_clk);
      n++;
    end while (reset_out !== lvl && n < 9);
    check(8'h3, 8'(n));
  endtask : req
  // k: negedge of ack after start, -1 before start, 99 never
  task automatic bus_cycle(input int w, input logic sys, input int k);
    int n;
    int exp;
    n = 0;
    exp = sys ? 3 + 2 * ((k + 2) / 2) : 3 + 2 * w;
    waits = 2'(w);
    sys_bus = sys;
    if (k < 0) async_ready_in_n = 1'h0;
    @(negedge core_clk);
    status_in = 2'h2;
    do begin
      if (n == k) async_ready_in_n = 1'h0;
      @(negedge core_clk);
      n++;
    end while (done_n !== 1'h0 && n < 20);
    check(8'(exp), 8'(n));
    status_in = 2'h3;
    async_ready_in_n = 1'h1;
    repeat (5) @(negedge core_clk);
    check(8'h1, {7'h0, done_n});
  endtask : bus_cycle
  initial begin
    logic p;
    repeat (16) @(negedge core_clk);
    check(8'h2, {5'h0, ready_oe_n, reset_out, periph_clk});
    rst_b = 1'h1;
    @(negedge core_clk);
    check(8'h1, {7'h0, reset_out});
    repeat (32) @(negedge core_clk);
    req(1'h0);
    // idle clock so the free-running phase differs from the aligned one
    @(negedge core_clk);
    bus_cycle(0, 1'h0, 99);
    p = periph_clk;
    check(8'h1, {7'h0, p});
    @(negedge core_clk);
    check(8'(!p), 8'(periph_clk));
    bus_cycle(1, 1'h0, 99);
    bus_cycle(3, 1'h0, 99);
    bus_cycle(2, 1'h0, -1);
    bus_cycle(0, 1'h1, -1);
    bus_cycle(0, 1'h1, 0);
    bus_cycle(0, 1'h1, 2);
    req(1'h1);
    repeat (32) @(negedge core_clk);
    check(8'h0, {6'h0, done_n, periph_clk});
    req(1'h0);
    bus_cycle(0, 1'h0, 99);
    test_done();
  end
  // tests need under two hundred clocks; this allows well over ten times that
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule : tb
`default_nettype wire

// ===== verilog/rws_cfg.svh
// timing constants and reset values for the ready, wait-state and reset block
// assumes includers use the values as plain sized literals
`ifndef RWS_CFG_SVH
`define RWS_CFG_SVH

// system clock rate in MHz
`define RWS_CLK_MHZ        50
// flip-flops in each pin synchroniser
`define RWS_SYNC_STAGES    2
// reset values of outputs and control flops
`define RWS_PCLK_RST       1'b0
`define RWS_RESET_OUT_RST  1'b1
`define RWS_READY_DRV_RST  1'b1
`define RWS_SYNC_RST       1'b1
// request seen as asserted until the pin shows otherwise
`define RWS_RREQ_SYNC_RST  1'b0

`endif

// ===== verilog/rws_pkg.sv
// types shared by the ready and reset block
// assumes the cfg header supplies numeric constants
`default_nettype none
package rws_pkg;

  // bus-cycle sequencing, one state per system clock
  typedef enum logic [2:0] {
    RWS_IDLE,
    RWS_STAT_P2,
    RWS_CMD_P1,
    RWS_CMD_P2
  } rws_state_t;

  // processor status lines, both high means no cycle pending
  typedef struct packed {
    logic bus_status_1_n;
    logic bus_status_0_n;
  } rws_status_t;

  // synchronous ready group from local wait-state logic and address decode
  typedef struct packed {
    logic sync_ready_in_n;
    logic sync_ready_enable_n;
    logic async_ready_enable_n;
  } rws_ready_sel_t;

endpackage : rws_pkg
`default_nettype wire

// ===== verilog/rws_top.sv
// ready generation, peripheral clock alignment and reset synchroniser
// assumes status, sync ready and enables are driven on core_clk;
// async ready and reset request may change at any time
//
// What this block does
// - system-bus ack on async ready, waits until low
// - each ready input gated by own enable
// - sync ready sampled ending phase one, drives done
// - async ready sampled one clock earlier, synchronised
// - wait only if both inputs inactive or disabled
// - resolved async ready masks sync ready afterwards
// - float done at cycle start, drive low once ready is seen, release in idle when that input goes high
// - hold cycle-done low during reset
// - reset output from request, synchronised falling edge
// - align peripheral clock at first cycle after reset
// - reset lags request by three clocks, SYNC_STAGES plus one
`timescale 1ns/1ps
`default_nettype none
`include "rws_cfg.svh"

module rws_top #(
  parameter int SYNC_STAGES = `RWS_SYNC_STAGES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire rws_pkg::rws_status_t    status_in,
  input  wire rws_pkg::rws_ready_sel_t ready_sel,
  input  wire logic                    async_ready_in_n,
  input  wire logic                    reset_request_n,
  output logic                         ready_out,
  output logic                         ready_oe_n,
  output logic                         reset_out,
  output logic                         periph_clk
);

  rws_pkg::rws_state_t state_q;
  rws_pkg::rws_state_t state_d;

  logic [SYNC_STAGES-1:0] async_sync_q;
  logic [SYNC_STAGES-1:0] rreq_sync_q;
  logic                   async_n;
  logic                   status_idle_q;
  logic                   cycle_start;
  logic                   async_hit_q;
  logic                   async_won_q;
  logic                   ready_drv_q;
  logic                   ready_drv_d;
  logic                   reset_out_q;
  logic                   pclk_q;
  logic                   align_pend_q;
  logic                   sync_hit;
  logic                   sel_high;

  // the first stage is only read by the next stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      async_sync_q <= {SYNC_STAGES{`RWS_SYNC_RST}};
    end else begin
      async_sync_q <= {async_sync_q[SYNC_STAGES-2:0], async_ready_in_n};
    end
  end

  assign async_n = async_sync_q[SYNC_STAGES-1];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // starts asserted so reset_out cannot dip as rst_b lifts
      rreq_sync_q <= {SYNC_STAGES{`RWS_RREQ_SYNC_RST}};
    end else begin
      rreq_sync_q <= {rreq_sync_q[SYNC_STAGES-2:0], reset_request_n};
    end
  end

  // both edges leave on core_clk, lagging the request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_out_q <= `RWS_RESET_OUT_RST;
    end else begin
      reset_out_q <= ~rreq_sync_q[SYNC_STAGES-1];
    end
  end

  assign reset_out = reset_out_q;

  // a cycle starts when either status line leaves the idle pair
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_idle_q <= 1'b1;
    end else begin
      status_idle_q <= status_in.bus_status_1_n & status_in.bus_status_0_n;
    end
  end

  assign cycle_start = status_idle_q & ~reset_out_q &
                       ~(status_in.bus_status_1_n & status_in.bus_status_0_n);

  // sync ready counts only while enabled and not masked by async
  assign sync_hit = ~ready_sel.sync_ready_enable_n &
                    ~ready_sel.sync_ready_in_n & ~async_won_q;

  // release condition: the input that ended the cycle went high
  assign sel_high = async_won_q ? async_n : ready_sel.sync_ready_in_n;

  always_comb begin
    state_d = state_q;
    case (state_q)
      rws_pkg::RWS_IDLE: begin
        if (cycle_start) begin
          state_d = rws_pkg::RWS_STAT_P2;
        end
      end
      rws_pkg::RWS_STAT_P2: begin
        state_d = rws_pkg::RWS_CMD_P1;
      end
      rws_pkg::RWS_CMD_P1: begin
        state_d = rws_pkg::RWS_CMD_P2;
      end
      rws_pkg::RWS_CMD_P2: begin
        // no ready driven means another command state
        state_d = ready_drv_q ? rws_pkg::RWS_IDLE : rws_pkg::RWS_CMD_P1;
      end
      default: begin
        state_d = rws_pkg::RWS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= rws_pkg::RWS_IDLE;
    end else if (reset_out_q) begin
      state_q <= rws_pkg::RWS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // async sampled at each command state start, resolved a clock later
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      async_hit_q <= 1'b0;
    end else if (state_d == rws_pkg::RWS_CMD_P1 &&
                 state_q != rws_pkg::RWS_CMD_P1) begin
      async_hit_q <= ~ready_sel.async_ready_enable_n & ~async_n;
    end else if (state_q == rws_pkg::RWS_IDLE) begin
      async_hit_q <= 1'b0;
    end
  end

  // sticky for the rest of the bus cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      async_won_q <= 1'b0;
    end else if (reset_out_q || cycle_start) begin
      async_won_q <= 1'b0;
    end else if (state_q == rws_pkg::RWS_CMD_P1 && async_hit_q) begin
      async_won_q <= 1'b1;
    end
  end

  always_comb begin
    ready_drv_d = ready_drv_q;
    if (reset_out_q) begin
      ready_drv_d = 1'b1;
    end else if (cycle_start) begin
      ready_drv_d = 1'b0;
    end else if (state_q == rws_pkg::RWS_CMD_P1) begin
      // end of phase one: either resolved input ends the cycle
      ready_drv_d = sync_hit | async_hit_q;
    end else if (state_q == rws_pkg::RWS_IDLE && sel_high) begin
      ready_drv_d = 1'b0;
    end
  end

  // drives low on the wired line; wait counters clear off this
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_drv_q <= `RWS_READY_DRV_RST;
    end else begin
      ready_drv_q <= ready_drv_d;
    end
  end

  // open drain: only ever pulls low, pull-up does the high level
  assign ready_out  = 1'b0;
  assign ready_oe_n = ~ready_drv_q;

  // phase is unknown after reset until the first cycle shows it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      align_pend_q <= 1'b1;
    end else if (reset_out_q) begin
      align_pend_q <= 1'b1;
    end else if (cycle_start) begin
      align_pend_q <= 1'b0;
    end
  end

  // status falls in phase one, so next edge enters phase two
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pclk_q <= `RWS_PCLK_RST;
    end else if (reset_out_q) begin
      pclk_q <= `RWS_PCLK_RST;
    end else if (cycle_start && align_pend_q) begin
      pclk_q <= 1'b0;
    end else begin
      pclk_q <= ~pclk_q;
    end
  end

  assign periph_clk = pclk_q;

endmodule : rws_top
`default_nettype wire
